//--- rtl/vf_ramp_core.sv
// Purpose: Output frequency ramp generator with a programmable V/f voltage curve.
// Assumes: Selector and forced-stop pins are asynchronous; other inputs share core_clk.
// Notes: Frequency moves at most one 0.1 Hz step per control tick.
`timescale 1ns/1ps
`default_nettype none
module vf_ramp_core #(
	parameter logic [7:0] FORCED_STOP_ALARM_CODE = 8'h5a // Arbitrary value.
) (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wr_data,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	output logic      [31:0] rd_data,
	input  wire logic        forced_stop_on,
	input  wire logic        ramp_set_select_lo,
	input  wire logic        ramp_set_select_hi,
	input  wire logic        limit_active,
	input  wire logic        boost_or_vector,
	input  wire logic [9:0]  input_voltage,
	output logic      [12:0] out_frequency,
	output logic      [9:0]  out_voltage,
	output logic             alarm_active,
	output logic      [7:0]  forced_stop_alarm_code,
	output logic             irq
);
	function automatic logic in_range(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
		return (v >= lo) && (v <= hi);
	endfunction : in_range

	function automatic logic [12:0] absdiff(input logic [12:0] a, input logic [12:0] b);
		return (a > b) ? 13'(a - b) : 13'(b - a);
	endfunction : absdiff

	logic [1:0]  stop_sync_r, lo_sync_r, hi_sync_r;
	logic        run_r, assigned_r;
	logic [12:0] max_freq_r, base_freq_r, target_r;
	logic [9:0]  base_volt_r, max_volt_r;
	logic [7:0]  code_r;
	vf_ramp_pkg::vf_point_type pt_r [0:1];
	logic [19:0] time_r [0:7];
	logic [19:0] fstop_time_r;
	logic [1:0]  shape_r;
	logic [3:0]  irq_stat_r, irq_mask_r;
	logic [31:0] rd_data_r;
	logic        irq_r, alarm_r;
	vf_ramp_pkg::ramp_state_type state_r;
	logic [12:0] freq_r, start_r, goal_r;
	logic        dir_up_r, moving_r;
	logic [47:0] err_r;
	logic [7:0]  tick_cnt_r;
	logic [9:0]  volt_r;

	// Pins cross into core_clk through two flops; only stage one feeds stage two.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			stop_sync_r <= 2'h3;
			lo_sync_r   <= 2'h0;
			hi_sync_r   <= 2'h0;
		end else begin
			stop_sync_r <= {stop_sync_r[0], forced_stop_on};
			lo_sync_r   <= {lo_sync_r[0], ramp_set_select_lo};
			hi_sync_r   <= {hi_sync_r[0], ramp_set_select_hi};
		end
	end

	// Register write decode and range acceptance; a rejected write keeps the old value.
	wire        is_time  = (addr >= vf_ramp_pkg::OFS_TIME_BASE) && (addr <= vf_ramp_pkg::OFS_TIME_LAST)
	                       && (addr[1:0] == 2'h0);
	wire [7:0]  time_ofs = 8'(addr - vf_ramp_pkg::OFS_TIME_BASE);
	wire [2:0]  time_idx = time_ofs[4:2];
	logic       wr_ok, wr_param;
	always_comb begin
		wr_param = 1'b1;
		wr_ok    = 1'b1;
		case (addr)
			vf_ramp_pkg::OFS_MAX_FREQ: wr_ok = in_range(wr_data, vf_ramp_pkg::FREQ_LIMIT_LO, vf_ramp_pkg::FREQ_LIMIT_HI);
			vf_ramp_pkg::OFS_BASE_FREQ: wr_ok = in_range(wr_data, vf_ramp_pkg::FREQ_LIMIT_LO, vf_ramp_pkg::FREQ_LIMIT_HI);
			vf_ramp_pkg::OFS_BASE_VOLT: wr_ok = (wr_data == 32'h0) ||
				in_range(wr_data, vf_ramp_pkg::VOLT_REG_LO, vf_ramp_pkg::VOLT_LIMIT_HI);
			vf_ramp_pkg::OFS_MAX_VOLT: wr_ok = in_range(wr_data, vf_ramp_pkg::VOLT_REG_LO, vf_ramp_pkg::VOLT_LIMIT_HI);
			vf_ramp_pkg::OFS_PT1_FREQ, vf_ramp_pkg::OFS_PT2_FREQ: wr_ok = (wr_data == 32'h0) ||
				in_range(wr_data, vf_ramp_pkg::PT_FREQ_LO, vf_ramp_pkg::FREQ_LIMIT_HI);
			vf_ramp_pkg::OFS_PT1_VOLT, vf_ramp_pkg::OFS_PT2_VOLT: wr_ok = (wr_data <= vf_ramp_pkg::VOLT_LIMIT_HI);
			vf_ramp_pkg::OFS_FSTOP_TIME: wr_ok = (wr_data <= vf_ramp_pkg::TIME_LIMIT_HI);
			vf_ramp_pkg::OFS_SHAPE: wr_ok = (wr_data <= vf_ramp_pkg::SHAPE_LIMIT);
			vf_ramp_pkg::OFS_TARGET: wr_ok = (wr_data <= vf_ramp_pkg::FREQ_LIMIT_HI);
			default: begin
				wr_param = is_time;
				wr_ok    = is_time ? (wr_data <= vf_ramp_pkg::TIME_LIMIT_HI) : 1'b1;
			end
		endcase
	end
	wire wr_take     = wr_en && wr_ok;
	wire wr_reject   = wr_en && wr_param && !wr_ok;
	wire alarm_clear = wr_en && (addr == vf_ramp_pkg::OFS_CTRL) && wr_data[vf_ramp_pkg::CTRL_CLEAR_BIT];

	// Parameter store; each register loads only on an accepted write to its offset.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			run_r        <= 1'b0;
			assigned_r   <= 1'b0;
			max_freq_r   <= vf_ramp_pkg::RST_MAX_FREQ;
			base_freq_r  <= vf_ramp_pkg::RST_BASE_FREQ;
			base_volt_r  <= vf_ramp_pkg::RST_BASE_VOLT;
			max_volt_r   <= vf_ramp_pkg::RST_MAX_VOLT;
			pt_r[0]      <= '0;
			pt_r[1]      <= '0;
			fstop_time_r <= vf_ramp_pkg::RST_TIME;
			shape_r      <= 2'h0;
			target_r     <= 13'h0000;
			irq_mask_r   <= 4'h0;
		end else if (wr_take) begin
			case (addr)
				vf_ramp_pkg::OFS_CTRL: begin
					run_r      <= wr_data[vf_ramp_pkg::CTRL_RUN_BIT];
					assigned_r <= wr_data[vf_ramp_pkg::CTRL_ASSIGN_BIT];
				end
				vf_ramp_pkg::OFS_MAX_FREQ:   max_freq_r   <= wr_data[12:0];
				vf_ramp_pkg::OFS_BASE_FREQ:  base_freq_r  <= wr_data[12:0];
				vf_ramp_pkg::OFS_BASE_VOLT:  base_volt_r  <= wr_data[9:0];
				vf_ramp_pkg::OFS_MAX_VOLT:   max_volt_r   <= wr_data[9:0];
				vf_ramp_pkg::OFS_PT1_FREQ:   pt_r[0].freq <= wr_data[12:0];
				vf_ramp_pkg::OFS_PT1_VOLT:   pt_r[0].volt <= wr_data[9:0];
				vf_ramp_pkg::OFS_PT2_FREQ:   pt_r[1].freq <= wr_data[12:0];
				vf_ramp_pkg::OFS_PT2_VOLT:   pt_r[1].volt <= wr_data[9:0];
				vf_ramp_pkg::OFS_FSTOP_TIME: fstop_time_r <= wr_data[19:0];
				vf_ramp_pkg::OFS_SHAPE:      shape_r      <= wr_data[1:0];
				vf_ramp_pkg::OFS_TARGET:     target_r     <= wr_data[12:0];
				vf_ramp_pkg::OFS_IRQ_MASK:   irq_mask_r   <= wr_data[3:0];
				default: ;
			endcase
		end
	end

	// Ramp time table held as an indexed array: accel at even, decel at odd index.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int i = 0; i < 8; i++) begin
				time_r[i] <= vf_ramp_pkg::RST_TIME;
			end
		end else if (wr_take && is_time) begin
			time_r[time_idx] <= wr_data[19:0];
		end
	end

	// Time set selection from the synchronised selector terminals.
	// Selector pair to set index.
	wire [1:0]  set_idx  = assigned_r ? {hi_sync_r[1], lo_sync_r[1]} : 2'h0;
	wire [19:0] acc_time = time_r[{set_idx, 1'b0}];
	wire [19:0] dec_time = time_r[{set_idx, 1'b1}];

	// Goal frequency; the run target is capped at the maximum output frequency.
	// Cap at maximum frequency.
	wire [12:0] run_goal = (target_r > max_freq_r) ? max_freq_r : target_r;
	wire [12:0] goal     = (state_r == vf_ramp_pkg::RS_RUN && run_r) ? run_goal : 13'h0000;
	wire        go_up    = goal > freq_r;
	wire        go_down  = goal < freq_r;
	wire        moving   = go_up || go_down;
	// Forced stop uses its own time.
	// Time spans zero to maximum frequency.
	wire [19:0] act_time = (state_r == vf_ramp_pkg::RS_FORCED_STOP) ? fstop_time_r : (go_up ? acc_time : dec_time);
	wire [33:0] thr_base = 34'(act_time) * 34'(vf_ramp_pkg::TICKS_PER_TIME_LSB);

	// Shape weights: the step rate is max_freq*kn over time*kd.
	wire [19:0] band_w   = (20'(max_freq_r) * 20'(vf_ramp_pkg::S_WEAK_PCT)) / 20'd100;
	wire [19:0] band_s   = (20'(max_freq_r) * 20'(vf_ramp_pkg::S_STRONG_PCT)) / 20'd100;
	wire [12:0] band_raw = (shape_r == vf_ramp_pkg::SHAPE_S_WEAK) ? band_w[12:0] : band_s[12:0];
	wire [12:0] band     = (band_raw == 13'h0000) ? 13'h0001 : band_raw;
	wire [12:0] d_start  = absdiff(freq_r, start_r);
	wire [12:0] d_goal   = absdiff(goal, freq_r);
	wire [12:0] d_near   = 13'(((d_start < d_goal) ? d_start : d_goal) + 13'h0001);
	wire [12:0] d_edge   = (d_near > band) ? band : d_near;
	logic [12:0] kn, kd;
	always_comb begin
		kn = 13'h0001;
		kd = 13'h0001;
		case (shape_r)
			// Rounded ends over the S band.
			// Middle slope equals the linear slope.
			vf_ramp_pkg::SHAPE_S_WEAK, vf_ramp_pkg::SHAPE_S_STRONG: begin
				kn = d_edge;
				kd = band;
			end
			// Rate falls as base over frequency.
			vf_ramp_pkg::SHAPE_CURVE: begin
				if (freq_r > base_freq_r) begin
					kn = base_freq_r;
					kd = freq_r;
				end
			end
			default: ;
		endcase
	end
	wire [47:0] inc     = 48'(max_freq_r) * 48'(kn);
	wire [47:0] thresh  = 48'(thr_base) * 48'(kd);
	wire [47:0] err_sum = 48'(err_r + inc);
	wire [47:0] err_rem = 48'(err_sum - thresh);
	wire        tick    = (tick_cnt_r == 8'(vf_ramp_pkg::TICK_CYCLES - 1));
	wire        restart = (goal != goal_r) || (moving && (go_up != dir_up_r));
	// Limiting holds the ramp, stretching it.
	wire        advance = tick && moving && !limit_active && !restart;
	wire        do_step = advance && (err_sum >= thresh);

	// Control tick divider and rate accumulator.
	// One step when accumulated rate passes threshold.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			tick_cnt_r <= 8'h00;
			err_r      <= 48'h0;
			freq_r     <= 13'h0000;
			start_r    <= 13'h0000;
			goal_r     <= 13'h0000;
			dir_up_r   <= 1'b1;
			moving_r   <= 1'b0;
		end else begin
			tick_cnt_r <= tick ? 8'h00 : 8'(tick_cnt_r + 8'h01);
			goal_r     <= goal;
			moving_r   <= moving;
			if (restart) begin
				err_r    <= 48'h0;
				start_r  <= freq_r;
				dir_up_r <= go_up;
			end else if (do_step) begin
				err_r  <= (err_rem >= thresh) ? 48'h0 : err_rem;
				freq_r <= go_up ? 13'(freq_r + 13'h0001) : 13'(freq_r - 13'h0001);
			end else if (advance) begin
				err_r <= err_sum;
			end
		end
	end

	// Stop sequencing: the terminal going off forces a stop, then the alarm latches.
	// Stop, then alarm until cleared.
	wire stopped  = (state_r == vf_ramp_pkg::RS_FORCED_STOP) && (freq_r == 13'h0000);
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_r <= vf_ramp_pkg::RS_RUN;
		end else begin
			case (state_r)
				vf_ramp_pkg::RS_RUN:         if (!stop_sync_r[1]) state_r <= vf_ramp_pkg::RS_FORCED_STOP;
				vf_ramp_pkg::RS_FORCED_STOP: if (stopped) state_r <= vf_ramp_pkg::RS_ALARM;
				vf_ramp_pkg::RS_ALARM:       if (alarm_clear && stop_sync_r[1]) state_r <= vf_ramp_pkg::RS_RUN;
				default:                     state_r <= vf_ramp_pkg::RS_RUN;
			endcase
		end
	end

	// V/f knots in rising order; disabled knots are skipped during the search.
	// Unregulated base point tracks input voltage.
	// Simple curve without points or maximum.
	// Boost or vector drops the same knots.
	wire         avr_off  = (base_volt_r == 10'h000);
	wire         vf_plain = avr_off || boost_or_vector;
	vf_ramp_pkg::vf_point_type knot [0:4];
	logic        knot_en [0:4];
	always_comb begin
		knot[0]    = '0;
		knot_en[0] = 1'b1;
		for (int i = 0; i < 2; i++) begin
			knot[i+1]    = pt_r[i];
			knot_en[i+1] = !vf_plain && (pt_r[i].freq != 13'h0000);
		end
		knot[3]    = '{freq: base_freq_r, volt: avr_off ? input_voltage : base_volt_r};
		knot_en[3] = 1'b1;
		knot[4]    = '{freq: max_freq_r, volt: max_volt_r};
		knot_en[4] = !vf_plain && (max_freq_r > base_freq_r);
	end
	vf_ramp_pkg::vf_point_type lo_k, up_k;
	logic        up_found;
	always_comb begin
		lo_k     = knot[0];
		up_k     = knot[0];
		up_found = 1'b0;
		for (int i = 1; i < 5; i++) begin
			if (knot_en[i] && knot[i].freq <= freq_r && knot[i].freq >= lo_k.freq) begin
				lo_k = knot[i];
			end
			if (knot_en[i] && knot[i].freq > freq_r && (!up_found || knot[i].freq < up_k.freq)) begin
				up_k     = knot[i];
				up_found = 1'b1;
			end
		end
	end
	wire        v_neg  = up_k.volt < lo_k.volt;
	wire [9:0]  v_span = v_neg ? 10'(lo_k.volt - up_k.volt) : 10'(up_k.volt - lo_k.volt);
	wire [12:0] f_off  = 13'(freq_r - lo_k.freq);
	wire [12:0] f_span = 13'(up_k.freq - lo_k.freq);
	wire [22:0] num    = up_found ? 23'(f_off) * 23'(v_span) : 23'h0;

	// Serial restoring divider interpolates within the active segment.
	logic        div_busy_r, div_neg_r;
	logic [4:0]  div_cnt_r;
	logic [22:0] quot_r;
	logic [13:0] rem_r;
	logic [12:0] den_r;
	logic [9:0]  base_v_r, vlim_r;
	wire  [13:0] rem_sh  = {rem_r[12:0], quot_r[22]};
	wire         rem_ge  = rem_sh >= {1'b0, den_r};
	wire  [10:0] v_sum   = div_neg_r ? 11'(base_v_r - quot_r[9:0]) : 11'(base_v_r + quot_r[9:0]);
	// Twenty-three shifts, then one cycle to publish, so the last quotient bit is in.
	wire         div_end = div_busy_r && (div_cnt_r == 5'd23);
	// Never above the available input voltage.
	wire  [9:0]  v_res   = (v_sum > 11'(vlim_r)) ? vlim_r : v_sum[9:0];
	always_ff @(posedge core_clk) begin
		if (rst) begin
			div_busy_r <= 1'b0;
			div_neg_r  <= 1'b0;
			div_cnt_r  <= 5'h00;
			quot_r     <= 23'h0;
			rem_r      <= 14'h0;
			den_r      <= 13'h0001;
			base_v_r   <= 10'h000;
			vlim_r     <= 10'h000;
			volt_r     <= 10'h000;
		end else if (!div_busy_r) begin
			div_busy_r <= 1'b1;
			div_cnt_r  <= 5'h00;
			quot_r     <= num;
			rem_r      <= 14'h0;
			den_r      <= up_found ? f_span : 13'h0001;
			div_neg_r  <= v_neg;
			base_v_r   <= lo_k.volt;
			vlim_r     <= input_voltage;
		end else if (div_end) begin
			div_busy_r <= 1'b0;
			volt_r     <= v_res;
		end else begin
			div_cnt_r <= 5'(div_cnt_r + 5'h01);
			rem_r     <= rem_ge ? 14'(rem_sh - {1'b0, den_r}) : rem_sh;
			quot_r    <= {quot_r[21:0], rem_ge};
		end
	end

	// Read decode; unmapped offsets read as zero.
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0;
		case (addr)
			vf_ramp_pkg::OFS_CTRL: begin
				rd_mux[vf_ramp_pkg::CTRL_RUN_BIT]    = run_r;
				rd_mux[vf_ramp_pkg::CTRL_ASSIGN_BIT] = assigned_r;
			end
			vf_ramp_pkg::OFS_MAX_FREQ:   rd_mux = 32'(max_freq_r);
			vf_ramp_pkg::OFS_BASE_FREQ:  rd_mux = 32'(base_freq_r);
			vf_ramp_pkg::OFS_BASE_VOLT:  rd_mux = 32'(base_volt_r);
			vf_ramp_pkg::OFS_MAX_VOLT:   rd_mux = 32'(max_volt_r);
			vf_ramp_pkg::OFS_PT1_FREQ:   rd_mux = 32'(pt_r[0].freq);
			vf_ramp_pkg::OFS_PT1_VOLT:   rd_mux = 32'(pt_r[0].volt);
			vf_ramp_pkg::OFS_PT2_FREQ:   rd_mux = 32'(pt_r[1].freq);
			vf_ramp_pkg::OFS_PT2_VOLT:   rd_mux = 32'(pt_r[1].volt);
			vf_ramp_pkg::OFS_FSTOP_TIME: rd_mux = 32'(fstop_time_r);
			vf_ramp_pkg::OFS_SHAPE:      rd_mux = 32'(shape_r);
			vf_ramp_pkg::OFS_TARGET:     rd_mux = 32'(target_r);
			vf_ramp_pkg::OFS_STATUS:     rd_mux = 32'(freq_r);
			vf_ramp_pkg::OFS_VOLT_OUT:   rd_mux = 32'(volt_r);
			vf_ramp_pkg::OFS_IRQ_STAT:   rd_mux = 32'(irq_stat_r);
			vf_ramp_pkg::OFS_IRQ_MASK:   rd_mux = 32'(irq_mask_r);
			vf_ramp_pkg::OFS_ALARM:      rd_mux = 32'(code_r);
			default:                     rd_mux = is_time ? 32'(time_r[time_idx]) : 32'h0;
		endcase
	end

	// Sticky events; a set landing with a one-to-clear write wins, so no event is lost.
	wire [3:0] irq_clr = (wr_take && (addr == vf_ramp_pkg::OFS_IRQ_STAT)) ? wr_data[3:0] : 4'h0;
	wire [3:0] irq_ev;
	assign irq_ev[vf_ramp_pkg::IRQ_REACHED_BIT] = moving_r && !moving;
	assign irq_ev[vf_ramp_pkg::IRQ_ALARM_BIT]   = stopped;
	assign irq_ev[vf_ramp_pkg::IRQ_REJECT_BIT]  = wr_reject;
	assign irq_ev[vf_ramp_pkg::IRQ_LIMIT_BIT]   = limit_active && moving;

	// Output flops: every top-level output comes from a register.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq_stat_r <= 4'h0;
			irq_r      <= 1'b0;
			alarm_r    <= 1'b0;
			code_r     <= 8'h00;
			rd_data_r  <= 32'h0;
		end else begin
			irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
			irq_r      <= |(irq_stat_r & irq_mask_r);
			alarm_r    <= (state_r == vf_ramp_pkg::RS_ALARM);
			code_r     <= (state_r == vf_ramp_pkg::RS_ALARM) ? FORCED_STOP_ALARM_CODE : 8'h00;
			rd_data_r  <= rd_en ? rd_mux : 32'h0;
		end
	end
	assign rd_data                = rd_data_r;
	assign out_frequency          = freq_r;
	assign out_voltage            = volt_r;
	assign alarm_active           = alarm_r;
	assign forced_stop_alarm_code = code_r;
	assign irq                    = irq_r;

	// Checks on the ramp step, the stop sequence and the read port.
	default clocking chk_cb @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_stop_done;
		(state_r == vf_ramp_pkg::RS_FORCED_STOP) && (freq_r == 13'h0000);
	endsequence
	a_step_on_tick: assert property (!$stable(freq_r) |-> $past(tick))
		else $error("Frequency moved off a control tick.");
	a_single_step: assert property (!$stable(freq_r) |-> (absdiff(freq_r, $past(freq_r)) == 13'h0001))
		else $error("Frequency moved by more than one step.");
	a_limit_holds: assert property (limit_active |=> $stable(freq_r))
		else $error("Frequency moved while limiting.");
	a_stop_to_alarm: assert property (s_stop_done |=> (state_r == vf_ramp_pkg::RS_ALARM))
		else $error("Stopped without entering the alarm state.");
	a_alarm_code: assert property (alarm_active |-> (forced_stop_alarm_code == FORCED_STOP_ALARM_CODE))
		else $error("Alarm shown without its code.");
	a_set_one_fixed: assert property (!assigned_r |-> (acc_time == time_r[0]))
		else $error("Unassigned selectors left set one.");
	a_read_quiet: assert property (!rd_en |=> (rd_data == 32'h0))
		else $error("Read data shown without a read strobe.");
endmodule : vf_ramp_core
`default_nettype wire

//--- rtl/vf_ramp_pkg.sv
// Purpose: Shared constants and types for the frequency ramp and V/f profile block.
// Assumes: Frequencies in 0.1 Hz, voltages in 1 V, ramp times in 0.01 s.
// Notes: Register offsets are byte addresses on the plain register port.
package vf_ramp_pkg;
	// Clock and control tick timing.
	localparam int CLK_PERIOD_NS      = 5;
	localparam int TICK_NS            = 1000;
	localparam int TICK_CYCLES        = TICK_NS / CLK_PERIOD_NS;
	localparam int TIME_LSB_NS        = 10_000_000;
	localparam int TICKS_PER_TIME_LSB = TIME_LSB_NS / TICK_NS;
	localparam int S_WEAK_PCT         = 5;
	localparam int S_STRONG_PCT       = 10;
	// Accepted parameter ranges.
	localparam logic [31:0] FREQ_LIMIT_LO = 32'h0000_00fa;
	localparam logic [31:0] FREQ_LIMIT_HI = 32'h0000_1388;
	localparam logic [31:0] PT_FREQ_LO    = 32'h0000_0001;
	localparam logic [31:0] VOLT_REG_LO   = 32'h0000_00a0;
	localparam logic [31:0] VOLT_LIMIT_HI = 32'h0000_01f4;
	localparam logic [31:0] TIME_LIMIT_HI = 32'h0005_7e40;
	localparam logic [31:0] SHAPE_LIMIT   = 32'h0000_0003;
	// Register byte offsets.
	localparam logic [7:0] OFS_CTRL       = 8'h00;
	localparam logic [7:0] OFS_MAX_FREQ   = 8'h04;
	localparam logic [7:0] OFS_BASE_FREQ  = 8'h08;
	localparam logic [7:0] OFS_BASE_VOLT  = 8'h0c;
	localparam logic [7:0] OFS_MAX_VOLT   = 8'h10;
	localparam logic [7:0] OFS_PT1_FREQ   = 8'h14;
	localparam logic [7:0] OFS_PT1_VOLT   = 8'h18;
	localparam logic [7:0] OFS_PT2_FREQ   = 8'h1c;
	localparam logic [7:0] OFS_PT2_VOLT   = 8'h20;
	localparam logic [7:0] OFS_TIME_BASE  = 8'h24;
	localparam logic [7:0] OFS_TIME_LAST  = 8'h40;
	localparam logic [7:0] OFS_FSTOP_TIME = 8'h44;
	localparam logic [7:0] OFS_SHAPE      = 8'h48;
	localparam logic [7:0] OFS_TARGET     = 8'h4c;
	localparam logic [7:0] OFS_STATUS     = 8'h50;
	localparam logic [7:0] OFS_VOLT_OUT   = 8'h54;
	localparam logic [7:0] OFS_IRQ_STAT   = 8'h58;
	localparam logic [7:0] OFS_IRQ_MASK   = 8'h5c;
	localparam logic [7:0] OFS_ALARM      = 8'h60;
	// Control and interrupt bit positions.
	localparam int CTRL_RUN_BIT      = 0;
	localparam int CTRL_ASSIGN_BIT   = 1;
	localparam int CTRL_CLEAR_BIT    = 2;
	localparam int IRQ_REACHED_BIT   = 0;
	localparam int IRQ_ALARM_BIT     = 1;
	localparam int IRQ_REJECT_BIT    = 2;
	localparam int IRQ_LIMIT_BIT     = 3;
	// Reset values.
	localparam logic [12:0] RST_MAX_FREQ  = 13'h0258;
	localparam logic [12:0] RST_BASE_FREQ = 13'h01f4;
	localparam logic [9:0]  RST_BASE_VOLT = 10'h000;
	localparam logic [9:0]  RST_MAX_VOLT  = 10'h190;
	localparam logic [19:0] RST_TIME      = 20'h00258;
	typedef enum logic [1:0] {
		SHAPE_LINEAR   = 2'h0,
		SHAPE_S_WEAK   = 2'h1,
		SHAPE_S_STRONG = 2'h2,
		SHAPE_CURVE    = 2'h3
	} shape_type;
	typedef enum logic [1:0] {RS_RUN, RS_FORCED_STOP, RS_ALARM} ramp_state_type;
	typedef struct packed {
		logic [12:0] freq;
		logic [9:0]  volt;
	} vf_point_type;
endpackage : vf_ramp_pkg

//--- testbench/frequency_ramp_and_vf_profile_tb.sv
// Purpose: Self-checking bench for the ramp generator and V/f curve.
// Assumes: A refused write leaves the register as it was and sets the reject flag.
// Notes: Short ramp times keep each ramp to a few dozen control ticks.
`timescale 1ns/1ps
`default_nettype none
module frequency_ramp_and_vf_profile_tb;
	localparam logic [7:0] CODE = 8'h3c; // Arbitrary value.
	localparam int         TMO  = 95000;
	logic        core_clk = 1'b0;
	logic        rst      = 1'b1;
	logic [7:0]  addr     = 8'h00;
	logic [31:0] wr_data  = 32'h0;
	logic        wr_en    = 1'b0;
	logic        rd_en    = 1'b0;
	logic        stop_on  = 1'b1;
	logic        sel_lo   = 1'b0;
	logic        sel_hi   = 1'b0;
	logic [9:0]  mains    = 10'h190;
	logic [31:0] rd_data;
	logic [12:0] freq;
	logic [9:0]  volt;
	logic [9:0]  in_volt;
	logic        limit;
	logic        boost;
	logic        alarm;
	logic [7:0]  code;
	logic        irq;
	logic [31:0] d;
	int          fail_count      = 0;
	int          samples_checked = 0;
	int          cycles          = 0;
	vf_ramp_core #(.FORCED_STOP_ALARM_CODE(CODE)) dut (.core_clk(core_clk), .rst(rst), .addr(addr),
		.wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .forced_stop_on(stop_on),
		.ramp_set_select_lo(sel_lo), .ramp_set_select_hi(sel_hi), .limit_active(limit),
		.boost_or_vector(boost), .input_voltage(in_volt), .out_frequency(freq), .out_voltage(volt),
		.alarm_active(alarm), .forced_stop_alarm_code(code), .irq(irq));
	motor_model motor (.core_clk(core_clk), .mains_level(mains), .out_frequency(freq),
		.out_voltage(volt), .input_voltage(in_volt), .limit_active(limit), .boost_or_vector(boost));
	// Clock at 200 MHz and a cycle ceiling against hangs.
	always #2.5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == TMO) begin
			fail_count++;
			stop_test();
		end
	end
	task automatic stop_test();
		if (fail_count == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : stop_test
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk);
		addr    <= a;
		wr_data <= v;
		wr_en   <= 1'b1;
		@(posedge core_clk);
		wr_en <= 1'b0;
	endtask : wr
	// Read data stand only in the cycle after the strobe.
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge core_clk);
		addr  <= a;
		rd_en <= 1'b1;
		@(posedge core_clk);
		rd_en <= 1'b0;
		#1;
		v = rd_data;
	endtask : rd
	// A good value is kept, a bad one is refused and flagged, then the flag is cleared.
	task automatic reject(input logic [7:0] a, input logic [31:0] bad, input logic [31:0] good);
		logic [31:0] v;
		wr(a, good);
		rd(a, v);
		check(v, good);
		wr(a, bad);
		rd(a, v);
		check(v, good);
		rd(vf_ramp_pkg::OFS_IRQ_STAT, v);
		check(32'(v[vf_ramp_pkg::IRQ_REJECT_BIT]), 32'h1);
		wr(vf_ramp_pkg::OFS_IRQ_STAT, 32'h1 << vf_ramp_pkg::IRQ_REJECT_BIT);
	endtask : reject
	// Set index k gets time t for both directions; every other set is the slowest.
	task automatic set_times(input int k, input logic [31:0] t);
		for (int i = 0; i < 8; i++) begin
			wr(vf_ramp_pkg::OFS_TIME_BASE + 8'(4 * i), (i / 2 == k) ? t : vf_ramp_pkg::TIME_LIMIT_HI);
		end
	endtask : set_times
	task automatic wait_freq(input logic [12:0] f);
		for (int i = 0; i < 60 * vf_ramp_pkg::TICK_CYCLES && freq !== f; i++) begin
			@(posedge core_clk);
			#1;
		end
		check(32'(freq), 32'(f));
	endtask : wait_freq
	task automatic near(input logic [31:0] seen, input int exp);
		check(32'(int'(seen) >= exp - 1 && int'(seen) <= exp + 1), 32'h1);
	endtask : near
	initial begin
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		// Reset values of the curve and time registers.
		rd(vf_ramp_pkg::OFS_MAX_FREQ, d);
		check(d, 32'(vf_ramp_pkg::RST_MAX_FREQ));
		rd(vf_ramp_pkg::OFS_BASE_FREQ, d);
		check(d, 32'(vf_ramp_pkg::RST_BASE_FREQ));
		rd(vf_ramp_pkg::OFS_BASE_VOLT, d);
		check(d, 32'(vf_ramp_pkg::RST_BASE_VOLT));
		rd(vf_ramp_pkg::OFS_MAX_VOLT, d);
		check(d, 32'(vf_ramp_pkg::RST_MAX_VOLT));
		for (int i = 0; i < 8; i++) begin
			rd(vf_ramp_pkg::OFS_TIME_BASE + 8'(4 * i), d);
			check(d, 32'(vf_ramp_pkg::RST_TIME));
		end
		// Range limits of eight fields, at both ends only for the base frequency.
		reject(vf_ramp_pkg::OFS_BASE_FREQ, vf_ramp_pkg::FREQ_LIMIT_HI + 1, vf_ramp_pkg::FREQ_LIMIT_HI);
		reject(vf_ramp_pkg::OFS_BASE_FREQ, vf_ramp_pkg::FREQ_LIMIT_LO - 1, vf_ramp_pkg::FREQ_LIMIT_LO);
		reject(vf_ramp_pkg::OFS_MAX_FREQ, vf_ramp_pkg::FREQ_LIMIT_LO - 1, vf_ramp_pkg::FREQ_LIMIT_HI);
		reject(vf_ramp_pkg::OFS_BASE_VOLT, vf_ramp_pkg::VOLT_REG_LO - 1, vf_ramp_pkg::VOLT_REG_LO);
		reject(vf_ramp_pkg::OFS_MAX_VOLT, vf_ramp_pkg::VOLT_LIMIT_HI + 1, vf_ramp_pkg::VOLT_REG_LO);
		reject(vf_ramp_pkg::OFS_PT1_FREQ, vf_ramp_pkg::FREQ_LIMIT_HI + 1, 32'h0);
		reject(vf_ramp_pkg::OFS_PT2_VOLT, vf_ramp_pkg::VOLT_LIMIT_HI + 1, 32'h0);
		reject(vf_ramp_pkg::OFS_FSTOP_TIME, vf_ramp_pkg::TIME_LIMIT_HI + 1, 32'h0);
		reject(vf_ramp_pkg::OFS_SHAPE, vf_ramp_pkg::SHAPE_LIMIT + 1, vf_ramp_pkg::SHAPE_LIMIT);
		for (int m = 0; m < 4; m++) begin
			wr(vf_ramp_pkg::OFS_SHAPE, 32'(m));
			rd(vf_ramp_pkg::OFS_SHAPE, d);
			check(d, 32'(m));
		end
		wr(vf_ramp_pkg::OFS_BASE_VOLT, 32'h0);
		wr(vf_ramp_pkg::OFS_SHAPE, 32'(vf_ramp_pkg::SHAPE_LINEAR));
		// The mask gates the interrupt, and writing a one clears the flag.
		wr(vf_ramp_pkg::OFS_BASE_FREQ, 32'h0);
		wr(vf_ramp_pkg::OFS_IRQ_MASK, 32'h0);
		@(posedge core_clk);
		#1;
		check(32'(irq), 32'h0);
		wr(vf_ramp_pkg::OFS_IRQ_MASK, 32'hffff_ffff);
		@(posedge core_clk);
		#1;
		check(32'(irq), 32'h1);
		wr(vf_ramp_pkg::OFS_IRQ_STAT, 32'h1 << vf_ramp_pkg::IRQ_REJECT_BIT);
		rd(vf_ramp_pkg::OFS_IRQ_STAT, d);
		check(32'(d[vf_ramp_pkg::IRQ_REJECT_BIT]), 32'h0);
		check(32'(irq), 32'h0);
		// Each selector code picks its own time pair.
		wr(vf_ramp_pkg::OFS_CTRL, (32'h1 << vf_ramp_pkg::CTRL_RUN_BIT) | (32'h1 << vf_ramp_pkg::CTRL_ASSIGN_BIT));
		for (int k = 0; k < 4; k++) begin
			set_times(k, (k == 0) ? 32'h1 : 32'h0);
			sel_lo <= k[0];
			sel_hi <= k[1];
			wr(vf_ramp_pkg::OFS_TARGET, 32'd20);
			if (k == 0) begin
				// Maximum 500.0 Hz in 0.01 s gives half a step per tick.
				repeat (20 * vf_ramp_pkg::TICK_CYCLES) @(posedge core_clk);
				#1;
				near(32'(freq), 10);
			end
			wait_freq(13'd20);
			if (k == 0) begin
				// Two full divider passes so the voltage reflects the settled frequency.
				repeat (60) @(posedge core_clk);
				#1;
				near(32'(volt), 400 * 20 / 250);
				wr(vf_ramp_pkg::OFS_BASE_VOLT, 32'd200);
				repeat (60) @(posedge core_clk);
				#1;
				near(32'(volt), 200 * 20 / 250);
				mains <= 10'h12c;
				repeat (60) @(posedge core_clk);
				#1;
				near(32'(volt), 200 * 20 / 250);
			end
			wr(vf_ramp_pkg::OFS_TARGET, 32'd0);
			wait_freq(13'd0);
		end
		// Without assigned selectors the first pair is used.
		wr(vf_ramp_pkg::OFS_CTRL, 32'h1 << vf_ramp_pkg::CTRL_RUN_BIT);
		set_times(0, 32'h0);
		wr(vf_ramp_pkg::OFS_TARGET, 32'd20);
		wait_freq(13'd20);
		wr(vf_ramp_pkg::OFS_TARGET, 32'd0);
		wait_freq(13'd0);
		wr(vf_ramp_pkg::OFS_CTRL, (32'h1 << vf_ramp_pkg::CTRL_RUN_BIT) | (32'h1 << vf_ramp_pkg::CTRL_ASSIGN_BIT));
		wr(vf_ramp_pkg::OFS_TARGET, 32'd20);
		repeat (40 * vf_ramp_pkg::TICK_CYCLES) @(posedge core_clk);
		#1;
		check(32'(freq < 13'd2), 32'h1);
		// Forced stop uses its own time even when every set is slow.
		set_times(3, 32'h0);
		wait_freq(13'd20);
		set_times(4, 32'h0);
		check(32'(alarm), 32'h0);
		stop_on <= 1'b0;
		wait_freq(13'd0);
		repeat (50) @(posedge core_clk);
		#1;
		check(32'(alarm), 32'h1);
		check(32'(code), 32'(CODE));
		rd(vf_ramp_pkg::OFS_IRQ_STAT, d);
		check(32'(d[vf_ramp_pkg::IRQ_ALARM_BIT]), 32'h1);
		stop_test();
	end
endmodule : frequency_ramp_and_vf_profile_tb
`default_nettype wire

//--- testbench/motor_model.sv
// Purpose: Behavioural supply and motor model on the far side of the ramp block.
// Assumes: The bench sets the supply level; the motor never forces current limiting.
// Notes: The supply is registered, so a step reaches the block one clock late.
`timescale 1ns/1ps
`default_nettype none
module motor_model (
	input  wire logic        core_clk,
	input  wire logic [9:0]  mains_level,
	input  wire logic [12:0] out_frequency,
	input  wire logic [9:0]  out_voltage,
	output logic      [9:0]  input_voltage,
	output logic             limit_active,
	output logic             boost_or_vector
);
	// Plain V/f drive with no limiting or boost, so the programmed times hold.
	assign limit_active    = 1'b0;
	assign boost_or_vector = 1'b0;
	// The supply follows the bench level after one clock.
	always_ff @(posedge core_clk) begin
		input_voltage <= mains_level;
	end
endmodule : motor_model
`default_nettype wire
